// ### serial_rx_defs.svh
`ifndef SERIAL_RX_DEFS_SVH
`define SERIAL_RX_DEFS_SVH
// oversampling and bit sampling points
`define OVS_TICKS 16
`define SAMPLE_A 4'h6
`define SAMPLE_B 4'h7
`define SAMPLE_C 4'h8
`define SAMPLE_LAST 4'hF
// transfer-mode field values
`define DPX_HALF_RX 2'h1
`define DPX_FULL 2'h3
// fifo usable depth per transfer mode
`define FIFO_DEPTH_HALF 3'h4
`define FIFO_DEPTH_FULL 3'h2
// receive fill level value meaning the full depth
`define FILL_LEVEL_FULL 2'h0
// data width in bits
`define FRAME_BITS 9
`endif

// ### serial_rx_pkg.sv
package serial_rx_pkg;
	typedef enum logic [1:0] {
		mode_uart,
		mode_io_clk_in,
		mode_io_clk_out
	} line_mode_e;
	typedef enum logic [1:0] {
		rx_idle,
		rx_start,
		rx_data,
		rx_stop
	} rx_state_e;
	typedef logic [8:0] frame_t;
endpackage : serial_rx_pkg

// ### rx_fifo.sv
`timescale 1ns/10ps
// small synchronous fifo; limit lets software shrink the usable depth
module rx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic flush,
	input wire logic [$clog2(DEPTH):0] limit,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] count
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wptr_reg;
	logic [AW-1:0] rptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	// full is judged against the configured limit, not only the array size
	assign in_ready = (count_reg < limit) && (count_reg < (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data = mem_reg[rptr_reg];
	assign count = count_reg;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// storage
	always_ff @(posedge clock) begin
		if (push) begin
			mem_reg[wptr_reg] <= in_data;
		end
	end

	// pointers and fill count
	always_ff @(posedge clock) begin
		if (srst || flush) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wptr_reg <= (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
			end
			if (pop) begin
				rptr_reg <= (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	overflow_guard_a: assert property (@(posedge clock) disable iff (srst)
		!(count_reg > (AW+1)'(DEPTH))) else $error("fifo count exceeds depth");
endmodule : rx_fifo

// ### serial_rx.sv
`timescale 1ns/10ps
`include "serial_rx_defs.svh"
// Behaviour
// - three mode-dependent error flags
// - status read clears all error flags
// - no fifo: late frame sets overrun
// - fifo absorbs frames; overrun only when full
// - clock output stops at overrun point
// - parity mismatch sets parity flag
// - clock in, double buffer: clock with empty tx sets underrun
// - clock out, double buffer: underrun after output stops
// - stop bit zero sets framing error
// - sixteen ticks per bit, majority of three
// - frame starts on valid start bit
// - io sampling edge per clock direction
// - shift bits, interrupt on full frame
// - double buffer sets buffer-full flag
// - fifo takes buffer data, fill-level interrupt
// - receive enable; auto-inhibit clears it
// - single buffer stops clock each frame
// - double buffer stops clock when both full
// - fifo full stops clock; read restarts
// - read via buffer; ninth bit field
// - wake-up: interrupt only ninth bit one
// - fifo depth four half, two full
module serial_rx
	import serial_rx_pkg::*;
#(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic serial_tick,
	input wire logic rx_line,
	input wire logic shift_clock_in,
	input wire logic [1:0] line_mode,
	input wire logic double_buffer_enable,
	input wire logic fifo_enable,
	input wire logic [1:0] transfer_mode,
	input wire logic [1:0] rx_fill_level,
	input wire logic auto_stop_on_count,
	input wire logic fifo_clear,
	input wire logic nine_bit_mode,
	input wire logic parity_enable,
	input wire logic parity_odd,
	input wire logic wakeup_select,
	input wire logic edge_select,
	input wire logic receive_enable_set,
	input wire logic receive_enable_clear,
	input wire logic status_read,
	input wire logic buffer_read,
	input wire logic tx_data_available,
	input wire logic tx_shift_empty,
	output logic receive_enable_bit,
	output logic overrun_flag,
	output logic parity_underrun_flag,
	output logic framing_flag,
	output logic rx_buffer_full_flag,
	output logic [7:0] data_buffer_reg,
	output logic ninth_bit_field,
	output logic receive_interrupt,
	output logic shift_clock_out
);
	line_mode_e mode;
	rx_state_e state_reg;
	logic [2:0] rx_sync_reg;
	logic [2:0] sck_sync_reg;
	logic [2:0] tick_sync_reg;
	logic rx_level_reg;
	logic sck_level_reg;
	logic tick_level_reg;
	logic tick_rise;
	logic sck_rise;
	logic sck_fall;
	logic [3:0] os_cnt_reg;
	logic [3:0] bit_cnt_reg;
	logic [2:0] votes_reg;
	logic [8:0] shift_reg;
	logic parity_bit_reg;
	logic sample_now;
	logic majority;
	logic frame_done;
	logic [8:0] frame_word;
	logic frame_parity_bad;
	logic frame_stop_bad;
	logic buf_full_reg;
	logic shift_held_reg;
	logic [8:0] held_word_reg;
	logic out_clk_reg;
	logic out_clk_stop;
	logic out_clk_stopped_reg;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic [$clog2(FIFO_DEPTH):0] fifo_count;
	logic [$clog2(FIFO_DEPTH):0] fifo_limit;
	logic fifo_active;
	logic buf_to_fifo;
	logic [3:0] data_bits;
	logic [8:0] buf_word_reg;
	localparam int CW = $clog2(FIFO_DEPTH) + 1;

	assign mode = line_mode_e'(line_mode);
	assign data_bits = (nine_bit_mode || (mode == mode_uart && parity_enable)) ? 4'h9 : 4'h8;
	// nine-bit frames cannot be kept in the byte-wide fifo
	assign fifo_active = fifo_enable && double_buffer_enable && !nine_bit_mode;
	assign fifo_limit = (transfer_mode == `DPX_FULL) ? CW'(`FIFO_DEPTH_FULL)
		: CW'(`FIFO_DEPTH_HALF);

	// pin synchronisers: decision once second and third stages agree
	always_ff @(posedge clock) begin
		if (srst) begin
			rx_sync_reg <= 3'h7;
			sck_sync_reg <= 3'h0;
			tick_sync_reg <= 3'h0;
			rx_level_reg <= 1'b1;
			sck_level_reg <= 1'b0;
			tick_level_reg <= 1'b0;
		end else begin
			rx_sync_reg <= {rx_sync_reg[1:0], rx_line};
			sck_sync_reg <= {sck_sync_reg[1:0], shift_clock_in};
			tick_sync_reg <= {tick_sync_reg[1:0], serial_tick};
			if (rx_sync_reg[1] == rx_sync_reg[2]) begin
				rx_level_reg <= rx_sync_reg[2];
			end
			if (sck_sync_reg[1] == sck_sync_reg[2]) begin
				sck_level_reg <= sck_sync_reg[2];
			end
			if (tick_sync_reg[1] == tick_sync_reg[2]) begin
				tick_level_reg <= tick_sync_reg[2];
			end
		end
	end
	assign tick_rise = tick_sync_reg[2] && tick_sync_reg[1] && !tick_level_reg;
	assign sck_rise = sck_sync_reg[2] && sck_sync_reg[1] && !sck_level_reg;
	assign sck_fall = !sck_sync_reg[2] && !sck_sync_reg[1] && sck_level_reg;

	// io sampling strobe: output clock rising edge, or chosen input edge
	always_comb begin
		sample_now = 1'b0;
		case (mode)
			mode_io_clk_out: sample_now = tick_rise && !out_clk_reg && !out_clk_stop
				&& receive_enable_bit;
			mode_io_clk_in: sample_now = edge_select ? sck_fall : sck_rise;
			default: sample_now = 1'b0;
		endcase
	end
	assign majority = (votes_reg[0] & votes_reg[1]) | (votes_reg[0] & votes_reg[2])
		| (votes_reg[1] & votes_reg[2]);

	// receive sequencer: 16x oversampling in uart, clocked shifting in io
	always_ff @(posedge clock) begin
		if (srst) begin
			state_reg <= rx_idle;
			os_cnt_reg <= 4'h0;
			bit_cnt_reg <= 4'h0;
			votes_reg <= 3'h0;
			shift_reg <= 9'h000;
			frame_done <= 1'b0;
			frame_stop_bad <= 1'b0;
		end else begin
			frame_done <= 1'b0;
			if (!receive_enable_bit) begin
				state_reg <= rx_idle;
				bit_cnt_reg <= 4'h0;
			end else if (mode != mode_uart) begin
				if (sample_now) begin
					shift_reg <= {rx_level_reg, shift_reg[8:1]};
					frame_stop_bad <= 1'b0;
					if (bit_cnt_reg == 4'h7) begin
						bit_cnt_reg <= 4'h0;
						frame_done <= 1'b1;
					end else begin
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
				end
			end else if (tick_rise) begin
				os_cnt_reg <= os_cnt_reg + 4'h1;
				if (os_cnt_reg == `SAMPLE_A) votes_reg[0] <= rx_level_reg;
				if (os_cnt_reg == `SAMPLE_B) votes_reg[1] <= rx_level_reg;
				if (os_cnt_reg == `SAMPLE_C) votes_reg[2] <= rx_level_reg;
				case (state_reg)
					rx_idle: begin
						os_cnt_reg <= 4'h0;
						if (!rx_level_reg) begin
							state_reg <= rx_start;
						end
					end
					rx_start: begin
						// a glitch shorter than half a bit is not a start bit
						if (os_cnt_reg == `SAMPLE_LAST) begin
							state_reg <= majority ? rx_idle : rx_data;
							bit_cnt_reg <= 4'h0;
						end
					end
					rx_data: begin
						if (os_cnt_reg == `SAMPLE_LAST) begin
							shift_reg <= {majority, shift_reg[8:1]};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
							if (bit_cnt_reg == data_bits - 4'h1) begin
								state_reg <= rx_stop;
							end
						end
					end
					rx_stop: begin
						// only the first stop bit is checked at its centre
						if (os_cnt_reg == `SAMPLE_C + 4'h1) begin
							frame_stop_bad <= !majority;
							frame_done <= 1'b1;
							state_reg <= rx_idle;
						end
					end
					default: state_reg <= rx_idle;
				endcase
			end
		end
	end

	// align the assembled word to the lsb and split off the parity bit
	always_comb begin
		frame_word = (data_bits == 4'h9) ? shift_reg : {1'b0, shift_reg[8:1]};
		parity_bit_reg = frame_word[8];
		frame_parity_bad = (mode == mode_uart) && parity_enable && !nine_bit_mode
			&& ((^frame_word[7:0] ^ parity_odd) != parity_bit_reg);
	end

	// buffer chain: shift register, buffer, then fifo
	assign buf_to_fifo = fifo_active && buf_full_reg && fifo_in_ready;
	always_ff @(posedge clock) begin
		if (srst) begin
			buf_full_reg <= 1'b0;
			shift_held_reg <= 1'b0;
			held_word_reg <= 9'h000;
			buf_word_reg <= 9'h000;
		end else begin
			if (buf_to_fifo || (buffer_read && !fifo_active)) begin
				buf_full_reg <= 1'b0;
			end
			if (frame_done) begin
				if (!buf_full_reg || buf_to_fifo || (buffer_read && !fifo_active)) begin
					buf_word_reg <= frame_word;
					buf_full_reg <= 1'b1;
				end else if (mode == mode_io_clk_out) begin
					// frame waits in the shift register while the clock is stopped
					shift_held_reg <= 1'b1;
					held_word_reg <= frame_word;
				end
			end else if (shift_held_reg && (!buf_full_reg || buf_to_fifo)) begin
				buf_word_reg <= held_word_reg;
				buf_full_reg <= 1'b1;
				shift_held_reg <= 1'b0;
			end
		end
	end

	// cpu view: fifo head while the fifo runs, else the buffer; parity is not kept in fifo
	always_ff @(posedge clock) begin
		if (srst) begin
			data_buffer_reg <= 8'h00;
			ninth_bit_field <= 1'b0;
		end else if (!fifo_active) begin
			data_buffer_reg <= buf_word_reg[7:0];
			ninth_bit_field <= buf_word_reg[8];
		end else if (fifo_out_valid) begin
			data_buffer_reg <= fifo_out_data;
		end
	end

	rx_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.srst(srst),
		.flush(fifo_clear || !fifo_active),
		.limit(fifo_limit),
		.in_valid(buf_to_fifo),
		.in_ready(fifo_in_ready),
		.in_data(buf_word_reg[7:0]),
		.out_valid(fifo_out_valid),
		.out_ready(buffer_read && fifo_active),
		.out_data(fifo_out_data),
		.count(fifo_count)
	);

	// output shift clock: halts when the buffer is full in single buffer mode, else when the whole receive chain is occupied
	always_comb begin
		if (!double_buffer_enable) begin
			out_clk_stop = buf_full_reg;
		end else if (!fifo_active) begin
			out_clk_stop = buf_full_reg && shift_held_reg;
		end else begin
			out_clk_stop = shift_held_reg && !fifo_in_ready;
		end
	end
	always_ff @(posedge clock) begin
		if (srst) begin
			out_clk_reg <= 1'b1;
			out_clk_stopped_reg <= 1'b0;
		end else begin
			out_clk_stopped_reg <= out_clk_stop;
			if (mode != mode_io_clk_out || !receive_enable_bit) begin
				out_clk_reg <= 1'b1;
			end else if (tick_rise && (!out_clk_stop || !out_clk_reg)) begin
				out_clk_reg <= !out_clk_reg;
			end
		end
	end
	assign shift_clock_out = out_clk_reg;

	// receive enable: software sets it, auto-inhibit clears it when all full
	always_ff @(posedge clock) begin
		if (srst) begin
			receive_enable_bit <= 1'b0;
		end else if (fifo_active && auto_stop_on_count && shift_held_reg
			&& !fifo_in_ready) begin
			receive_enable_bit <= 1'b0;
		end else if (receive_enable_set) begin
			receive_enable_bit <= 1'b1;
		end else if (receive_enable_clear) begin
			receive_enable_bit <= 1'b0;
		end
	end

	// error flags: hardware set wins over the clearing status read
	always_ff @(posedge clock) begin
		if (srst) begin
			overrun_flag <= 1'b0;
			parity_underrun_flag <= 1'b0;
			framing_flag <= 1'b0;
		end else begin
			if (status_read) begin
				overrun_flag <= 1'b0;
				parity_underrun_flag <= 1'b0;
				framing_flag <= 1'b0;
			end
			if (frame_done && mode != mode_io_clk_out && buf_full_reg && !buf_to_fifo
				&& !(buffer_read && !fifo_active)) begin
				overrun_flag <= 1'b1;
			end
			if (frame_done && frame_parity_bad) begin
				parity_underrun_flag <= 1'b1;
			end
			if (mode == mode_io_clk_in && double_buffer_enable && sample_now
				&& bit_cnt_reg == 4'h0 && tx_shift_empty && !tx_data_available) begin
				parity_underrun_flag <= 1'b1;
			end
			if (mode == mode_io_clk_out && double_buffer_enable && out_clk_stop
				&& !out_clk_stopped_reg) begin
				parity_underrun_flag <= 1'b1;
			end
			if (frame_done && mode == mode_uart && frame_stop_bad) begin
				framing_flag <= 1'b1;
			end
		end
	end

	// interrupt: per frame, or at the fill level with fifo; wake-up filter
	always_ff @(posedge clock) begin
		if (srst) begin
			receive_interrupt <= 1'b0;
			rx_buffer_full_flag <= 1'b0;
		end else begin
			rx_buffer_full_flag <= buf_full_reg && double_buffer_enable;
			if (fifo_active) begin
				receive_interrupt <= buf_to_fifo && (fifo_count + CW'(1) ==
					((rx_fill_level == `FILL_LEVEL_FULL) ? fifo_limit
					: CW'(rx_fill_level)));
			end else begin
				receive_interrupt <= frame_done && !(wakeup_select && nine_bit_mode
					&& !frame_word[8]);
			end
		end
	end

	framing_io_zero_a: assert property (@(posedge clock) disable iff (srst)
		(mode != mode_uart && !status_read && $past(!framing_flag)) |-> !framing_flag)
		else $error("framing flag set in io mode");
	read_clears_a: assert property (@(posedge clock) disable iff (srst)
		status_read && !frame_done |=> !framing_flag) else $error("read did not clear");
	fifo_depth_a: assert property (@(posedge clock) disable iff (srst)
		fifo_count <= fifo_limit) else $error("fifo past usable depth");
	clock_halt_a: assert property (@(posedge clock) disable iff (srst)
		out_clk_stop && out_clk_reg |=> $stable(out_clk_reg)) else $error("clock ran");
	wakeup_filter_a: assert property (@(posedge clock) disable iff (srst)
		frame_done && !fifo_active && wakeup_select && nine_bit_mode && !frame_word[8]
		|=> !receive_interrupt) else $error("wake-up interrupt leaked");
	buffer_full_a: assert property (@(posedge clock) disable iff (srst)
		frame_done && !buf_full_reg |=> buf_full_reg) else $error("buffer not loaded");
	overrun_set_a: assert property (@(posedge clock) disable iff (srst)
		frame_done && mode == mode_uart && buf_full_reg && !fifo_active && !buffer_read
		|=> overrun_flag && $stable(data_buffer_reg)) else $error("overrun missed");
	auto_stop_a: assert property (@(posedge clock) disable iff (srst)
		fifo_active && auto_stop_on_count && shift_held_reg && !fifo_in_ready
		|=> !receive_enable_bit) else $error("auto-inhibit failed");
	frame_seen_c: cover property (@(posedge clock) disable iff (srst) frame_done);
	overrun_seen_c: cover property (@(posedge clock) disable iff (srst) $rose(overrun_flag));
	fifo_full_c: cover property (@(posedge clock) disable iff (srst) !fifo_in_ready);
endmodule : serial_rx

// ### serial_peer.sv
`timescale 1ns/10ps
// far-side serial peer: uart sender, clocked sender, and slave to our shift clock
module serial_peer (
	input wire logic serial_tick,
	input wire logic shift_clock_out,
	output logic rx_line,
	output logic shift_clock_in
);
	logic [7:0] out_word;
	int out_idx = 8;
	// both lines idle high before any frame
	initial begin
		rx_line = 1'b1;
		shift_clock_in = 1'b1;
	end
	task automatic ticks(input int n);
		repeat (n) @(posedge serial_tick);
	endtask : ticks
	// one uart frame, lsb first; stop level is a parameter so a bad stop can be forced
	task automatic send_uart(input logic [8:0] d, input int nb, input logic stop);
		rx_line = 1'b0;
		ticks(16);
		for (int i = 0; i < nb; i++) begin
			rx_line = d[i];
			ticks(16);
		end
		rx_line = stop;
		ticks(16);
		rx_line = 1'b1; // idle high between frames
		ticks(32);
	endtask : send_uart
	// low pulse far shorter than half a bit
	task automatic glitch();
		rx_line = 1'b0;
		ticks(3);
		rx_line = 1'b1;
		ticks(48);
	endtask : glitch
	// clocked byte on the peer's own clock, which stands still outside the frame
	task automatic send_io(input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			shift_clock_in = 1'b0;
			rx_line = d[i];
			ticks(4);
			shift_clock_in = 1'b1;
			ticks(4);
		end
		rx_line = ~d[7]; // released: never leave the last bit looking valid
		ticks(8);
	endtask : send_io
	// slave mode: first bit set up now, the rest change on falling edges
	task automatic load_out(input logic [7:0] d);
		out_word = d;
		out_idx = 0;
		rx_line = d[0];
	endtask : load_out
	always @(posedge shift_clock_out) begin
		if (out_idx < 8) out_idx++;
	end
	always @(negedge shift_clock_out) begin
		if (out_idx < 8) rx_line = out_word[out_idx];
		else rx_line = ~out_word[7];
	end
endmodule : serial_peer

// ### serial_rx_test.sv
`timescale 1ns/10ps
module serial_rx_test;
	import serial_rx_pkg::*;
	logic clock, srst, serial_tick, rx_line, shift_clock_in, fifo_clear, nine_bit_mode;
	logic [1:0] line_mode, transfer_mode, rx_fill_level;
	logic double_buffer_enable, fifo_enable, auto_stop_on_count, parity_enable, parity_odd;
	logic wakeup_select, edge_select, receive_enable_set, receive_enable_clear, status_read;
	logic buffer_read, tx_data_available, tx_shift_empty, receive_enable_bit, overrun_flag;
	logic parity_underrun_flag, framing_flag, rx_buffer_full_flag, ninth_bit_field;
	logic receive_interrupt, shift_clock_out;
	logic [7:0] data_buffer_reg;
	int num_errors = 0;
	int n_compared = 0;
	int n_irq = 0;
	int cycles = 0;
	int base;
	serial_rx #(.FIFO_DEPTH(8)) dut (.clock, .srst, .serial_tick, .rx_line, .shift_clock_in,
		.line_mode, .double_buffer_enable, .fifo_enable, .transfer_mode, .rx_fill_level,
		.auto_stop_on_count, .fifo_clear, .nine_bit_mode, .parity_enable, .parity_odd,
		.wakeup_select, .edge_select, .receive_enable_set, .receive_enable_clear, .status_read,
		.buffer_read, .tx_data_available, .tx_shift_empty, .receive_enable_bit, .overrun_flag,
		.parity_underrun_flag, .framing_flag, .rx_buffer_full_flag, .data_buffer_reg,
		.ninth_bit_field, .receive_interrupt, .shift_clock_out);
	serial_peer peer (.serial_tick, .shift_clock_out, .rx_line, .shift_clock_in);
	// system clock and the unrelated oversample tick
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial begin
		serial_tick = 1'b0;
		#3;
		forever #32 serial_tick = ~serial_tick;
	end
	// count interrupt pulses; cut a hang short well above the expected run
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (receive_interrupt === 1'b1) n_irq <= n_irq + 1;
		if (cycles == 90000) begin
			num_errors++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		if (num_errors == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_of_test
	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc
	// one-cycle pulse: 0 status read, 1 buffer read, 2 enable set, 3 enable clear, 4 flush
	task automatic pulse(input int k);
		@(posedge clock);
		case (k)
			0: status_read <= 1'b1;
			1: buffer_read <= 1'b1;
			2: receive_enable_set <= 1'b1;
			3: receive_enable_clear <= 1'b1;
			default: fifo_clear <= 1'b1;
		endcase
		@(posedge clock);
		{status_read, buffer_read, receive_enable_set, receive_enable_clear, fifo_clear} <= '0;
		cyc(2);
	endtask : pulse
	task automatic wait_irq(input int b);
		int i;
		i = 0;
		while (n_irq == b && i < 20000) begin
			@(posedge clock);
			i++;
		end
		cyc(2);
		check("interrupt seen", n_irq != b, 1'b1);
	endtask : wait_irq
	task automatic t_reset();
		check("flags after reset", {receive_enable_bit, overrun_flag, parity_underrun_flag,
			framing_flag, rx_buffer_full_flag, ninth_bit_field}, 9'h000);
		check("buffer after reset", data_buffer_reg, 9'h000);
		check("shift clock idle", shift_clock_out, 1'b1);
	endtask : t_reset
	task automatic t_uart();
		pulse(2);
		check("receive enable", receive_enable_bit, 1'b1);
		base = n_irq;
		peer.send_uart(9'h0A5, 8, 1'b1);
		wait_irq(base);
		check("uart data", data_buffer_reg, 9'h0A5);
		check("buffer full", rx_buffer_full_flag, 1'b1);
		check("no framing", framing_flag, 1'b0);
		pulse(1);
		check("full cleared", rx_buffer_full_flag, 1'b0);
	endtask : t_uart
	task automatic t_parity();
		@(posedge clock);
		parity_enable <= 1'b1;
		peer.send_uart(9'h15A, 9, 1'b1); // even parity of 5A is 0, send 1
		cyc(10);
		check("parity error", parity_underrun_flag, 1'b1);
		check("parity bit kept", ninth_bit_field, 1'b1);
		pulse(0);
		check("parity cleared", parity_underrun_flag, 1'b0);
		pulse(1);
		peer.send_uart(9'h05A, 9, 1'b1);
		cyc(10);
		check("good parity", parity_underrun_flag, 1'b0);
		pulse(1);
		@(posedge clock);
		parity_enable <= 1'b0;
	endtask : t_parity
	task automatic t_framing();
		peer.send_uart(9'h033, 8, 1'b0);
		cyc(10);
		check("framing error", framing_flag, 1'b1);
		pulse(0);
		check("framing cleared", framing_flag, 1'b0);
		pulse(1);
	endtask : t_framing
	task automatic t_overrun();
		peer.send_uart(9'h011, 8, 1'b1);
		peer.send_uart(9'h022, 8, 1'b1);
		cyc(10);
		check("overrun", overrun_flag, 1'b1);
		check("buffer kept", data_buffer_reg, 9'h011);
		pulse(0);
		check("overrun cleared", overrun_flag, 1'b0);
		pulse(1);
	endtask : t_overrun
	task automatic t_wakeup();
		@(posedge clock);
		nine_bit_mode <= 1'b1;
		wakeup_select <= 1'b1;
		base = n_irq;
		peer.send_uart(9'h055, 9, 1'b1);
		cyc(10);
		check("no wake", n_irq - base, 9'h000);
		pulse(1);
		peer.send_uart(9'h1AA, 9, 1'b1);
		wait_irq(base);
		check("ninth bit", {ninth_bit_field, data_buffer_reg}, 9'h1AA);
		pulse(1);
		@(posedge clock);
		nine_bit_mode <= 1'b0;
		wakeup_select <= 1'b0;
	endtask : t_wakeup
	task automatic t_refused();
		pulse(3);
		check("enable off", receive_enable_bit, 1'b0);
		base = n_irq;
		peer.send_uart(9'h0FF, 8, 1'b1);
		pulse(2);
		peer.glitch();
		cyc(10);
		check("nothing taken", n_irq - base, 9'h000);
	endtask : t_refused
	task automatic t_io_in();
		@(posedge clock);
		line_mode <= 2'h1;
		tx_shift_empty <= 1'b1;
		tx_data_available <= 1'b0;
		base = n_irq;
		peer.send_io(8'hC6);
		wait_irq(base);
		check("io in data", data_buffer_reg, 9'h0C6);
		check("underrun", parity_underrun_flag, 1'b1);
		check("framing fixed", framing_flag, 1'b0);
		pulse(0);
		pulse(1);
		@(posedge clock);
		tx_shift_empty <= 1'b0;
		tx_data_available <= 1'b1;
	endtask : t_io_in
	task automatic t_io_out();
		int t;
		logic last;
		@(posedge clock);
		line_mode <= 2'h2;
		double_buffer_enable <= 1'b0;
		peer.load_out(8'h3C);
		base = n_irq;
		wait_irq(base);
		check("io out data", data_buffer_reg, 9'h03C);
		t = 0;
		last = shift_clock_out;
		repeat (300) begin
			@(posedge clock);
			if (shift_clock_out !== last) t++;
			last = shift_clock_out;
		end
		check("clock stopped", t, 9'h000);
		peer.load_out(8'hC3);
		base = n_irq;
		pulse(1);
		wait_irq(base);
		check("io out second", data_buffer_reg, 9'h0C3);
		pulse(0);
		@(posedge clock);
		line_mode <= 2'h0;
		double_buffer_enable <= 1'b1;
		pulse(1);
	endtask : t_io_out
	task automatic t_fifo();
		logic [7:0] b [4] = '{8'h81, 8'h42, 8'h24, 8'h18};
		@(posedge clock);
		fifo_enable <= 1'b1;
		transfer_mode <= 2'h1;
		pulse(4);
		base = n_irq;
		for (int i = 0; i < 4; i++) peer.send_uart({1'b0, b[i]}, 8, 1'b1);
		cyc(10);
		check("fill level irq", n_irq - base, 9'h001);
		check("no fifo overrun", overrun_flag, 1'b0);
		check("full moved on", rx_buffer_full_flag, 1'b0);
		for (int i = 0; i < 4; i++) begin
			check("fifo order", data_buffer_reg, {1'b0, b[i]});
			pulse(1);
		end
	endtask : t_fifo
	// everything driven at time zero, then five cycles of reset
	initial begin
		{srst, double_buffer_enable, transfer_mode} = 4'hF;
		{line_mode, fifo_enable, rx_fill_level, auto_stop_on_count, fifo_clear} = 7'h00;
		{nine_bit_mode, parity_enable, parity_odd, wakeup_select, edge_select} = 5'h00;
		{receive_enable_set, receive_enable_clear, status_read, buffer_read} = 4'h0;
		{tx_data_available, tx_shift_empty} = 2'h2;
		repeat (5) @(posedge clock);
		srst <= 1'b0;
		cyc(1);
		t_reset();
		t_uart();
		t_parity();
		t_framing();
		t_overrun();
		t_wakeup();
		t_refused();
		t_io_in();
		t_io_out();
		t_fifo();
		end_of_test();
	end
endmodule : serial_rx_test
